// ===== operating_watchdog_timer.sv
// Summary of operation
// - Six-bit counter after twelve-bit prescaler
// - Counts only the crystal clock
// - Overflow times out at fixed cycle counts
// - Service write clears counter, upper prescaler
// - Service read returns reset vector low
// - Reset pin low 32 cycles, flag set
// - Stop instruction clears the prescaler
// - Internal reset clears both counters
// - Reset vector fetch clears the prescaler
// - Disable option suppresses watchdog resets
// - Monitor mode high voltage disables watchdog
// - Break with reset high voltage disables
// - No CPU interrupt from the watchdog
// - Keeps counting during wait mode
// - Stop gates clock, counter frozen
// - Stop honoured only when enabled
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module operating_watchdog_timer #(
  parameter logic [7:0] RST_VEC_LO = wdog_pkg::RST_VEC_LO_DEF // Vector low byte
) (
  input wire logic clk, // Crystal oscillator clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [wdog_pkg::APB_AW-1:0] paddr, // APB byte address
  input wire logic [wdog_pkg::APB_DW-1:0] pwdata, // APB write data
  output logic [wdog_pkg::APB_DW-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire wdog_pkg::sys_t sys, // Core events and modes
  input wire logic irq_hv, // High voltage on interrupt pin
  input wire logic rst_hv, // High voltage on reset pin
  output logic rst_pin_o, // Reset pin output value
  output logic rst_pin_oe, // Reset pin drive enable
  output logic reset_req, // Reset request to system logic
  output logic irq // Event status line
);
  import wdog_pkg::*;

  // Pin synchronisers
  logic [1:0] irq_hv_q; // Interrupt pin level stages
  logic [1:0] rst_hv_q; // Reset pin level stages
  logic irq_hv_s; // Synchronised interrupt pin level
  logic rst_hv_s; // Synchronised reset pin level

  // Counting state
  logic [PRESC_W-1:0] presc_r; // System prescaler
  logic [CNT_W-1:0] cnt_r; // Timeout counter
  logic stopped_r; // Stop mode active
  logic tick; // Counter advance
  logic ovf; // Counter overflow
  logic wd_off; // Watchdog disabled
  logic clr_all; // Both counters cleared

  // Register state
  ctrl_t ctrl_r; // Option bits
  logic [EV_W-1:0] status_r; // Sticky events
  logic [EV_W-1:0] mask_r; // Event mask
  logic rstat_r; // Watchdog reset flag
  logic [EV_W-1:0] ev_set; // Events this cycle

  // Reset pulse state
  pulse_st_t pulse_st_r; // Pulse state
  logic [5:0] pulse_cnt_r; // Pulse length count

  // Bus decode
  logic setup_ph; // Setup phase
  logic access_ph; // Access phase
  logic svc_wr; // Service location written
  logic [APB_DW-1:0] rd_nxt; // Read data for this address
  logic err_nxt; // Unmapped address
  logic [APB_DW-1:0] prdata_r; // Captured read data
  logic pslverr_r; // Captured error

  // Two-stage synchronisers for the pin levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_hv_q <= 2'h0;
      rst_hv_q <= 2'h0;
    end else begin
      irq_hv_q <= {irq_hv_q[0], irq_hv};
      rst_hv_q <= {rst_hv_q[0], rst_hv};
    end
  end
  assign irq_hv_s = irq_hv_q[1];
  assign rst_hv_s = rst_hv_q[1];

  // Disable terms
  assign wd_off = ctrl_r.disable_opt
    | (sys.monitor_mode & (irq_hv_s | rst_hv_s))
    | (sys.break_state & rst_hv_s);

  // Bus phases
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign svc_wr = access_ph & pwrite & (paddr == SERVICE_ADDR);

  // Counter advance taps; wait mode has no effect here
  always_comb begin
    if (ctrl_r.short_sel) begin
      tick = &presc_r[SHORT_TAP-1:0];
    end else begin
      tick = &presc_r;
    end
  end
  assign ovf = tick & (&cnt_r) & ~stopped_r & ~wd_off;
  assign clr_all = sys.int_reset | ovf;

  // Prescaler, run from the crystal clock only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= '0;
    end else if (clr_all || stopped_r || sys.vec_fetch) begin
      presc_r <= '0;
    end else if (sys.stop_instr) begin
      presc_r <= '0;
    end else if (svc_wr) begin
      presc_r <= {{(PRESC_W-SVC_KEEP){1'b0}}, presc_r[SVC_KEEP-1:0]};
    end else begin
      presc_r <= presc_r + 1'b1;
    end
  end

  // Timeout counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (clr_all || svc_wr || wd_off) begin
      cnt_r <= '0;
    end else if (stopped_r) begin // Frozen in stop
      cnt_r <= cnt_r;
    end else if (tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Stop mode tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stopped_r <= 1'b0;
    end else if (clr_all || sys.stop_exit) begin // Leave on wake or reset
      stopped_r <= 1'b0;
    end else if (sys.stop_instr && ctrl_r.stop_en) begin
      stopped_r <= 1'b1;
    end
  end

  // Reset pulse generator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_st_r <= PULSE_IDLE;
      pulse_cnt_r <= 6'h00;
    end else begin
      unique case (pulse_st_r)
        PULSE_IDLE: begin
          if (ovf) begin // Start the pin pulse
            pulse_st_r <= PULSE_ACTIVE;
            pulse_cnt_r <= 6'h00;
          end
        end
        PULSE_ACTIVE: begin
          if (pulse_cnt_r == PULSE_LAST) begin // Pulse done
            pulse_st_r <= PULSE_IDLE;
          end else begin
            pulse_cnt_r <= pulse_cnt_r + 6'h01;
          end
        end
      endcase
    end
  end

  // Reset request, one cycle per overflow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_req <= 1'b0;
    end else begin
      reset_req <= ovf;
    end
  end

  // Open-drain reset pin, driven low while active
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = (pulse_st_r == PULSE_ACTIVE);

  // Option register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= ctrl_t'(CTRL_RESET);
    end else if (access_ph && pwrite && paddr == CTRL_ADDR) begin
      ctrl_r.short_sel <= pwdata[CTRL_SHORT_BIT];
      ctrl_r.disable_opt <= pwdata[CTRL_DIS_BIT];
      ctrl_r.stop_en <= pwdata[CTRL_STOPEN_BIT];
    end
  end

  // Mask register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= MASK_RESET;
    end else if (access_ph && pwrite && paddr == MASK_ADDR) begin
      mask_r <= pwdata[EV_W-1:0];
    end
  end

  // Event sources
  always_comb begin
    ev_set = '0;
    ev_set[EV_RESET_BIT] = ovf;
    ev_set[EV_SERVICE_BIT] = svc_wr;
    ev_set[EV_STOP_BIT] = sys.stop_instr & ctrl_r.stop_en & ~stopped_r;
  end

  // Sticky status; read clears only bits returned, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= '0;
    end else if (access_ph && !pwrite && paddr == STATUS_ADDR) begin
      status_r <= (status_r & ~prdata_r[EV_W-1:0]) | ev_set;
    end else begin
      status_r <= status_r | ev_set;
    end
  end

  // Reset status flag; read clears, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstat_r <= 1'b0;
    end else if (ovf) begin
      rstat_r <= 1'b1;
    end else if (access_ph && !pwrite && paddr == RSTAT_ADDR && prdata_r[RSTAT_WD_BIT]) begin
      rstat_r <= 1'b0;
    end
  end

  // Event line for bus software, never a CPU request
  assign irq = |(status_r & mask_r);

  // Read mux
  always_comb begin
    rd_nxt = '0;
    err_nxt = 1'b0;
    unique case (paddr)
      SERVICE_ADDR: rd_nxt[7:0] = RST_VEC_LO;
      CTRL_ADDR: rd_nxt[2:0] = ctrl_r;
      STATUS_ADDR: rd_nxt[EV_W-1:0] = status_r;
      MASK_ADDR: rd_nxt[EV_W-1:0] = mask_r;
      RSTAT_ADDR: rd_nxt[RSTAT_WD_BIT] = rstat_r;
      COUNT_ADDR: begin
        rd_nxt[PRESC_W-1:0] = presc_r;
        rd_nxt[COUNT_CNT_LSB+CNT_W-1:COUNT_CNT_LSB] = cnt_r;
        rd_nxt[COUNT_STOP_BIT] = stopped_r;
        rd_nxt[COUNT_PULSE_BIT] = rst_pin_oe;
      end
      default: err_nxt = 1'b1; // Unmapped
    endcase
  end

  // Capture read data and error in the setup phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= pwrite ? '0 : rd_nxt;
      pslverr_r <= err_nxt;
    end
  end

  // Bus answers in the first access cycle
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = access_ph & pslverr_r;

  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_pulse_width: assert property ($rose(rst_pin_oe) |-> rst_pin_oe [*8] ##24 rst_pin_oe
    ##1 !rst_pin_oe) else $error("reset pulse length wrong");
  a_flag_set: assert property (reset_req |-> rstat_r && rst_pin_oe)
    else $error("watchdog flag or pulse missing");
  a_overflow_cause: assert property (reset_req |-> $past(cnt_r) == 6'h3F && !$past(wd_off))
    else $error("reset without overflow");
  a_service_clear: assert property (svc_wr && !clr_all && !stopped_r && !sys.vec_fetch
    && !sys.stop_instr |=> cnt_r == '0 && presc_r[PRESC_W-1:SVC_KEEP] == '0
    && presc_r[SVC_KEEP-1:0] == $past(presc_r[SVC_KEEP-1:0]))
    else $error("service did not clear counters");
  a_disable_quiet: assert property (ctrl_r.disable_opt |=> !reset_req)
    else $error("reset while disabled");
  a_monitor_off: assert property (sys.monitor_mode && (irq_hv_s || rst_hv_s) |=> !reset_req)
    else $error("reset in monitor high voltage");
  a_break_off: assert property (sys.break_state && rst_hv_s |=> !reset_req)
    else $error("reset in break high voltage");
  a_stop_frozen: assert property (stopped_r && $past(stopped_r) && !clr_all
    && !svc_wr && !wd_off |=> $stable(cnt_r) && presc_r == '0)
    else $error("counter moved in stop");
  a_stop_gate: assert property (sys.stop_instr && !ctrl_r.stop_en && !stopped_r |=> !stopped_r)
    else $error("stop honoured while disabled");
  a_stop_clear: assert property (sys.stop_instr |=> presc_r == '0)
    else $error("stop left prescaler");
  a_vec_fetch: assert property (sys.vec_fetch |=> presc_r == '0)
    else $error("vector fetch left prescaler");
  a_int_reset: assert property (sys.int_reset |=> presc_r == '0 && cnt_r == '0)
    else $error("internal reset left counters");
  a_count_run: assert property (rst_n && !wd_off && !stopped_r && !clr_all && !svc_wr
    && !sys.vec_fetch && !sys.stop_instr |=> presc_r == $past(presc_r) + 12'h001)
    else $error("prescaler stalled");

endmodule : operating_watchdog_timer
`default_nettype wire

// ===== sw_model.sv
`timescale 1ns/1ns
`default_nettype none
module sw_model (
  input wire logic clk, // Crystal clock
  input wire logic [wdog_pkg::APB_DW-1:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  output logic psel, // Select
  output logic penable, // Enable
  output logic pwrite, // Direction
  output logic [wdog_pkg::APB_AW-1:0] paddr, // Byte address
  output logic [wdog_pkg::APB_DW-1:0] pwdata // Write data
);
  import wdog_pkg::*;
  // Bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // One transfer, held until pready is seen high
  task xfer(input logic w, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d,
            output logic [APB_DW-1:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // Service from the main flow, any data value
  task service();
    logic [APB_DW-1:0] q;
    logic e;
    xfer(1'b1, SERVICE_ADDR, 32'h0000_00A5, q, e);
  endtask : service
endmodule : sw_model
`default_nettype wire

// ===== tb_operating_watchdog_timer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_operating_watchdog_timer;
  import wdog_pkg::*;
  logic clk, rst_n, irq_hv, rst_hv; // Clock, reset, pin levels
  sys_t sys; // Core events
  logic psel, penable, pwrite, pready, pslverr; // Bus control
  logic [APB_AW-1:0] paddr; // Address
  logic [APB_DW-1:0] pwdata, prdata; // Data
  logic rst_pin_o, rst_pin_oe, reset_req, irq; // Outputs
  int err_count = 0; // Mismatches
  int checks = 0; // Comparisons
  int f, o; // First reset cycle, pulse length
  operating_watchdog_timer #(.RST_VEC_LO(8'h5A)) dut (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys(sys), .irq_hv(irq_hv),
    .rst_hv(rst_hv), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .reset_req(reset_req), .irq(irq));
  sw_model sw (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Verdict and end of run
  task final_report();
    $display("Comparisons %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // Compare a design value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Compare a bench count against a range
  task chk_rng(input int v, input int lo, input int hi);
    checks++;
    if (v < lo || v > hi) begin
      err_count++;
      $display("Error at %0t: count %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask : chk_rng
  // Read and compare data and error
  task rd(input logic [APB_AW-1:0] a, input logic [31:0] exp, input logic e_exp);
    logic [31:0] q;
    logic e;
    sw.xfer(1'b0, a, '0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, e_exp});
  endtask : rd
  task wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    sw.xfer(1'b1, a, d, q, e);
  endtask : wr
  // Watch n cycles for a reset request and the pin pulse
  task watch(input int n, output int first, output int oe_n);
    first = -1;
    oe_n = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (reset_req === 1'b1 && first < 0) first = i;
      if (rst_pin_oe === 1'b1) oe_n++;
    end
  endtask : watch
  // Reset values, unmapped access, service read
  task t_regs();
    rd(CTRL_ADDR, 32'h0, 1'b0);
    rd(STATUS_ADDR, 32'h0, 1'b0);
    rd(20'h00020, 32'h0, 1'b1);
    rd(SERVICE_ADDR, 32'h5A, 1'b0);
  endtask : t_regs
  // Short timeout, pulse, flags, interrupt line
  task t_timeout();
    wr(MASK_ADDR, 32'h1);
    wr(CTRL_ADDR, 32'h1);
    sw.service();
    watch(9000, f, o);
    chk_rng(f, 8170, 8200);
    chk_rng(o, 32, 32);
    chk({31'h0, rst_pin_o}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd(RSTAT_ADDR, 32'h1, 1'b0);
    rd(STATUS_ADDR, 32'h3, 1'b0);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_timeout
  // Regular services keep reset away
  task t_service();
    for (int i = 0; i < 3; i++) begin
      sw.service();
      watch(5000, f, o);
      chk_rng(f, -1, -1);
    end
  endtask : t_service
  task t_disable();
    wr(CTRL_ADDR, 32'h3);
    sw.service();
    watch(9000, f, o);
    chk_rng(f, -1, -1);
    wr(CTRL_ADDR, 32'h1);
  endtask : t_disable
  // High voltage in monitor and break states
  task t_hv();
    sys.monitor_mode <= 1'b1;
    irq_hv <= 1'b1;
    sw.service();
    watch(9000, f, o);
    chk_rng(f, -1, -1);
    sys.monitor_mode <= 1'b0;
    irq_hv <= 1'b0;
    sys.break_state <= 1'b1;
    rst_hv <= 1'b1;
    watch(9000, f, o);
    chk_rng(f, -1, -1);
    sys.break_state <= 1'b0;
    rst_hv <= 1'b0;
  endtask : t_hv
  // Stop refused, then honoured and left
  task t_stop();
    sw.service();
    sys.stop_instr <= 1'b1;
    @(posedge clk);
    sys.stop_instr <= 1'b0;
    watch(9000, f, o);
    chk_rng(f, 8170, 8200);
    wr(CTRL_ADDR, 32'h5);
    sw.service();
    sys.stop_instr <= 1'b1;
    @(posedge clk);
    sys.stop_instr <= 1'b0;
    watch(9000, f, o);
    chk_rng(f, -1, -1);
    sys.stop_exit <= 1'b1;
    @(posedge clk);
    sys.stop_exit <= 1'b0;
    watch(9000, f, o);
    chk_rng(f, 0, 8200);
  endtask : t_stop
  // Option and mask readback, internal reset and vector fetch on live counters
  task t_sys();
    rd(CTRL_ADDR, 32'h5, 1'b0);
    rd(MASK_ADDR, 32'h1, 1'b0);
    sys.int_reset <= 1'b1;
    @(posedge clk);
    sys.int_reset <= 1'b0;
    rd(COUNT_ADDR, 32'h1, 1'b0);
    repeat (3) @(posedge clk);
    sys.vec_fetch <= 1'b1;
    @(posedge clk);
    sys.vec_fetch <= 1'b0;
    rd(COUNT_ADDR, 32'h1, 1'b0);
  endtask : t_sys
  // Main sequence
  initial begin
    rst_n = 1'b0;
    irq_hv = 1'b0;
    rst_hv = 1'b0;
    sys = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_timeout();
    t_service();
    t_disable();
    t_hv();
    t_stop();
    t_sys();
    final_report();
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    $display("Error at %0t: run did not finish", $time);
    final_report();
  end
endmodule : tb_operating_watchdog_timer
`default_nettype wire

// ===== wdog_pkg.sv
package wdog_pkg;

  // Bus geometry
  localparam int APB_AW = 20; // Byte address width
  localparam int APB_DW = 32; // Data width

  // Counter geometry
  localparam int PRESC_W = 12; // Prescaler width
  localparam int CNT_W = 6; // Timeout counter width
  localparam int SVC_KEEP = 4; // Prescaler bits kept by a service
  localparam int SHORT_TAP = 7; // Prescaler bits per count, short timeout

  // Timeouts in crystal cycles, for reference and checking
  localparam int TIMEOUT_LONG_CYC = (1 << 18) - (1 << 4); // Long timeout
  localparam int TIMEOUT_SHORT_CYC = (1 << 13) - (1 << 4); // Short timeout

  // Reset pin pulse length in crystal cycles
  localparam int PULSE_CYC = 32;
  localparam logic [5:0] PULSE_LAST = 6'(PULSE_CYC - 1); // Final count

  // Register indices and byte addresses
  localparam logic [APB_AW-1:0] SERVICE_IDX = 20'h0FFFF; // Service location
  localparam logic [APB_AW-1:0] SERVICE_ADDR = 20'(SERVICE_IDX << 2);
  localparam logic [APB_AW-1:0] CTRL_ADDR = 20'h00000; // Option bits
  localparam logic [APB_AW-1:0] STATUS_ADDR = 20'h00004; // Sticky events
  localparam logic [APB_AW-1:0] MASK_ADDR = 20'h00008; // Event mask
  localparam logic [APB_AW-1:0] RSTAT_ADDR = 20'h0000C; // Reset status
  localparam logic [APB_AW-1:0] COUNT_ADDR = 20'h00010; // Live counters

  // Control field positions
  localparam int CTRL_SHORT_BIT = 0; // Short timeout select
  localparam int CTRL_DIS_BIT = 1; // Watchdog disable option
  localparam int CTRL_STOPEN_BIT = 2; // Stop instruction enable
  localparam logic [2:0] CTRL_RESET = 3'h0; // Control reset value

  // Status and mask field positions
  localparam int EV_RESET_BIT = 0; // Watchdog reset issued
  localparam int EV_SERVICE_BIT = 1; // Service write seen
  localparam int EV_STOP_BIT = 2; // Stop mode entered
  localparam int EV_W = 3; // Event count
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0; // Mask reset value

  // Reset status field
  localparam int RSTAT_WD_BIT = 0; // Watchdog caused last reset

  // Count register layout
  localparam int COUNT_CNT_LSB = 12; // Counter field position
  localparam int COUNT_STOP_BIT = 20; // Stopped flag position
  localparam int COUNT_PULSE_BIT = 21; // Pulse active position

  // Default reset vector low byte, arbitrary
  localparam logic [7:0] RST_VEC_LO_DEF = 8'h00;

  // Option fields held by software
  typedef struct packed {
    logic stop_en; // Stop instruction honoured
    logic disable_opt; // Watchdog resets suppressed
    logic short_sel; // Short timeout chosen
  } ctrl_t;

  // System events from the core, same clock
  typedef struct packed {
    logic stop_instr; // Stop instruction executes, pulse
    logic stop_exit; // Stop mode ends, pulse
    logic vec_fetch; // Reset vector fetch, pulse
    logic int_reset; // Other internal reset, pulse
    logic monitor_mode; // Monitor mode level
    logic break_state; // Break state level
  } sys_t;

  // Reset pulse states
  typedef enum logic {PULSE_IDLE, PULSE_ACTIVE} pulse_st_t;

endpackage : wdog_pkg
